/* hdl/dfd_decode.sv */
// front-end decoder for the dsp extended instruction set.
// assumes the fetch path hands one 16-bit word per valid cycle, in program
// order, with its pc; a redirect makes fetch restart at the given pc.
`timescale 1ns/10ps
module dfd_decode
  import dfd_pkg::*;
(
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire logic                          fw_valid_in,
  input  wire logic [dfd_pkg::HALF_W-1:0]    fw_word_in,
  input  wire logic [dfd_pkg::ADDR_W-1:0]    fw_pc_in,
  input  wire logic                          priv_in,
  input  wire logic                          dsp_wr_in,
  input  wire logic                          dsp_wdata_in,
  input  wire logic [dfd_pkg::CODE_W-1:0]    opnd_in,
  input  wire logic [dfd_pkg::XY_W-1:0]      xy_addr_in,
  input  wire logic [dfd_pkg::XY_W-1:0]      xy_step_in,
  input  wire logic                          xy_is_y_in,
  output logic                               iss_valid_out,
  output logic      [dfd_pkg::GRP_W-1:0]     iss_grp_out,
  output logic      [dfd_pkg::CODE_W-1:0]    iss_code_out,
  output logic      [dfd_pkg::ADDR_W-1:0]    iss_pc_out,
  output logic                               iss_long_out,
  output logic      [dfd_pkg::FA_W-1:0]      xfer_field_out,
  output logic      [dfd_pkg::HALF_W-1:0]    op_field_out,
  output logic                               x_xfer_out,
  output logic                               y_xfer_out,
  output logic                               alu_op_out,
  output logic                               mul_op_out,
  output logic                               dspreg_acc_out,
  output logic                               dspreg_load_out,
  output logic      [dfd_pkg::SEL_W-1:0]     dspreg_sel_out,
  output logic                               illegal_out,
  output logic                               dsp_en_out,
  output logic                               rpt_active_out,
  output logic                               redirect_out,
  output logic      [dfd_pkg::ADDR_W-1:0]    redirect_pc_out,
  output logic      [dfd_pkg::XY_W-1:0]      xy_addr_next_out
);

  // **************************************************************************
  // state
  // **************************************************************************
  dfd_state_type         st_reg, st_next;
  logic [HALF_W-1:0]     upper_reg;
  logic [ADDR_W-1:0]     upper_pc_reg;
  logic                  dsp_en_reg;
  logic [RC_W-1:0]       rc_reg, rc_next;
  logic [ADDR_W-1:0]     rs_reg, rs_next;
  logic [ADDR_W-1:0]     re_reg, re_next;
  logic                  dmx_reg, dmx_next;
  logic                  dmy_reg, dmy_next;
  logic [XY_W-1:0]       ms_reg, ms_next;
  logic [XY_W-1:0]       me_reg, me_next;

  // **************************************************************************
  // word classification
  // **************************************************************************
  wire logic [5:0] pfx_w   = fw_word_in[PFX_MSB:PFX_LSB];
  wire logic       w_ddt   = (pfx_w == PFX_DDT);
  wire logic       w_sdt   = (pfx_w == PFX_SDT);
  wire logic       w_dop   = (pfx_w == PFX_DOP);
  wire logic       w_rsv   = (pfx_w == PFX_RSV);

  wire logic       c_setrc_r = dfd_hit(fw_word_in, M_RS, P_SETRC_R);
  wire logic       c_setrc_i = dfd_hit(fw_word_in, M_IMM, P_SETRC_I);
  wire logic       c_ldrs    = dfd_hit(fw_word_in, M_IMM, P_LDRS);
  wire logic       c_ldre    = dfd_hit(fw_word_in, M_IMM, P_LDRE);
  wire logic       c_ldmod   = dfd_hit(fw_word_in, M_RS, P_LDMOD);
  wire logic       c_ldrs_r  = dfd_hit(fw_word_in, M_RS, P_LDRS_R);
  wire logic       c_ldre_r  = dfd_hit(fw_word_in, M_RS, P_LDRE_R);
  wire logic       c_setdmx  = dfd_hit(fw_word_in, M_FULL, P_SETDMX);
  wire logic       c_setdmy  = dfd_hit(fw_word_in, M_FULL, P_SETDMY);
  wire logic       c_clrdm   = dfd_hit(fw_word_in, M_FULL, P_CLRDM);
  wire logic [SEL_W-1:0] sel_w = fw_word_in[SEL_MSB:SEL_LSB];
  wire logic       sel_dsp_w = (sel_w >= DSPREG_SEL_MIN);
  wire logic       c_lds     = dfd_hit(fw_word_in, M_REG, P_LDSDSP) && sel_dsp_w;
  wire logic       c_sts     = dfd_hit(fw_word_in, M_REG, P_STSDSP) && sel_dsp_w;

  wire logic       w_rpt = c_setrc_r | c_setrc_i | c_ldrs | c_ldre | c_ldrs_r | c_ldre_r;
  wire logic       w_mod = c_ldmod | c_setdmx | c_setdmy | c_clrdm;
  wire logic       w_sys = w_rpt | w_mod | c_lds | c_sts;
  wire logic       w_dsp = w_sys | w_ddt | w_sdt | w_dop | w_rsv;

  // **************************************************************************
  // word assembly and issue
  // **************************************************************************
  wire logic in_idle  = (st_reg == ST_IDLE);
  wire logic in_half  = (st_reg == ST_HALF);
  // a disabled dsp word never reaches an execution unit
  wire logic bad16    = in_idle && fw_valid_in && w_dsp && (!dsp_en_reg || w_rsv);
  wire logic take_up  = in_idle && fw_valid_in && w_dop && dsp_en_reg;
  wire logic take16   = in_idle && fw_valid_in && !take_up && !bad16;
  // lower half is whatever word follows, so any word alignment works
  wire logic take32   = in_half && fw_valid_in;
  wire logic issue_w  = take16 || take32;
  wire logic sys_go   = take16 && w_sys && dsp_en_reg;

  wire logic [CODE_W-1:0] code_w = take32 ? {upper_reg, fw_word_in}
                                          : {{HALF_W{1'b0}}, fw_word_in};
  wire logic [ADDR_W-1:0] pc_w   = take32 ? upper_pc_reg : fw_pc_in;

  wire logic [GRP_W-1:0] grp_w;
  assign grp_w[GRP_SYS] = take16 && w_sys;
  assign grp_w[GRP_DDT] = take16 && w_ddt;
  assign grp_w[GRP_SDT] = take16 && w_sdt;
  assign grp_w[GRP_DOP] = take32;

  // field a is the low part of the first word in both transfer forms
  wire logic [FA_W-1:0]   fa_w  = take32 ? upper_reg[FA_W-1:0] : fw_word_in[FA_W-1:0];
  wire logic [HALF_W-1:0] fb_w  = take32 ? fw_word_in : {HALF_W{1'b0}};
  wire logic              xy_ok = take32 || (take16 && w_ddt);
  wire logic              x_w   = xy_ok && (fa_w[XOP_MSB:XOP_LSB] != 2'h0);
  wire logic              y_w   = xy_ok && (fa_w[YOP_MSB:YOP_LSB] != 2'h0);
  wire logic              alu_w = take32 && (fb_w[ALU_MSB:ALU_LSB] != 4'h0);
  wire logic              mul_w = take32 && fb_w[MUL_BIT];

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (take_up) begin
          st_next = ST_HALF;
        end
      end
      ST_HALF: begin
        if (fw_valid_in) begin
          st_next = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // **************************************************************************
  // repeat loop unit
  // **************************************************************************
  // loop back is decided when the end instruction issues, so fetch sees the
  // start pc in the very next cycle and no branch slot is spent
  wire logic rpt_act_w = (rc_reg != '0) && dsp_en_reg;
  wire logic loop_end  = issue_w && rpt_act_w && (pc_w == re_reg);
  wire logic loop_back = loop_end && (rc_reg != RC_ONE);
  wire logic [ADDR_W-1:0] disp_w =
    ADDR_W'({fw_word_in[IMM_MSB:IMM_LSB], 1'b0});

  always_comb begin
    rc_next = rc_reg;
    rs_next = rs_reg;
    re_next = re_reg;
    if (loop_end) begin
      rc_next = RC_W'(rc_reg - RC_ONE);
    end
    if (sys_go && c_setrc_r) begin
      rc_next = opnd_in[RC_W-1:0];
    end
    if (sys_go && c_setrc_i) begin
      rc_next = RC_W'(fw_word_in[IMM_MSB:IMM_LSB]);
    end
    if (sys_go && c_ldrs) begin
      rs_next = ADDR_W'(fw_pc_in + disp_w);
    end
    if (sys_go && c_ldre) begin
      re_next = ADDR_W'(fw_pc_in + disp_w);
    end
    if (sys_go && c_ldrs_r) begin
      rs_next = opnd_in;
    end
    if (sys_go && c_ldre_r) begin
      re_next = opnd_in;
    end
  end

  // **************************************************************************
  // modulo control
  // **************************************************************************
  always_comb begin
    dmx_next = dmx_reg;
    dmy_next = dmy_reg;
    ms_next  = ms_reg;
    me_next  = me_reg;
    if (sys_go && c_setdmx) begin
      dmx_next = 1'b1;
      dmy_next = 1'b0;
    end
    if (sys_go && c_setdmy) begin
      dmx_next = 1'b0;
      dmy_next = 1'b1;
    end
    if (sys_go && c_clrdm) begin
      dmx_next = 1'b0;
      dmy_next = 1'b0;
    end
    if (sys_go && c_ldmod) begin
      me_next = opnd_in[MOD_END_MSB:MOD_END_LSB];
      ms_next = opnd_in[XY_W-1:0];
    end
  end

  wire logic [XY_W-1:0] xy_next_w;
  wire logic            wrap_en_w = dsp_en_reg && (xy_is_y_in ? dmy_reg : dmx_reg);

  dfd_modulo u_modulo (
    .addr_in    (xy_addr_in),
    .step_in    (xy_step_in),
    .start_in   (ms_reg),
    .end_in     (me_reg),
    .wrap_en_in (wrap_en_w),
    .next_out   (xy_next_w)
  );

  // only a privileged write may change the enable
  wire logic dsp_en_next = (dsp_wr_in && priv_in) ? dsp_wdata_in : dsp_en_reg;

  // **************************************************************************
  // registers
  // **************************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg       <= ST_IDLE;
      upper_reg    <= '0;
      upper_pc_reg <= '0;
      dsp_en_reg   <= 1'b0;
      rc_reg       <= '0;
      rs_reg       <= '0;
      re_reg       <= '0;
      dmx_reg      <= 1'b0;
      dmy_reg      <= 1'b0;
      ms_reg       <= '0;
      me_reg       <= '0;
    end else if (ce_in) begin
      st_reg       <= st_next;
      if (take_up) begin
        upper_reg    <= fw_word_in;
        upper_pc_reg <= fw_pc_in;
      end
      dsp_en_reg   <= dsp_en_next;
      rc_reg       <= rc_next;
      rs_reg       <= rs_next;
      re_reg       <= re_next;
      dmx_reg      <= dmx_next;
      dmy_reg      <= dmy_next;
      ms_reg       <= ms_next;
      me_reg       <= me_next;
    end
  end

  // issue stage: all fields of one instruction leave in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iss_valid_out    <= 1'b0;
      iss_grp_out      <= '0;
      iss_code_out     <= '0;
      iss_pc_out       <= '0;
      iss_long_out     <= 1'b0;
      xfer_field_out   <= '0;
      op_field_out     <= '0;
      x_xfer_out       <= 1'b0;
      y_xfer_out       <= 1'b0;
      alu_op_out       <= 1'b0;
      mul_op_out       <= 1'b0;
      dspreg_acc_out   <= 1'b0;
      dspreg_load_out  <= 1'b0;
      dspreg_sel_out   <= '0;
      illegal_out      <= 1'b0;
    end else if (ce_in) begin
      iss_valid_out    <= issue_w;
      iss_grp_out      <= grp_w;
      iss_code_out     <= code_w;
      iss_pc_out       <= (issue_w || bad16) ? pc_w : iss_pc_out;
      iss_long_out     <= take32;
      xfer_field_out   <= fa_w;
      op_field_out     <= fb_w;
      x_xfer_out       <= x_w;
      y_xfer_out       <= y_w;
      alu_op_out       <= alu_w;
      mul_op_out       <= mul_w;
      dspreg_acc_out   <= sys_go && (c_lds || c_sts);
      dspreg_load_out  <= sys_go && c_lds;
      dspreg_sel_out   <= sel_w;
      illegal_out      <= bad16;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dsp_en_out       <= 1'b0;
      rpt_active_out   <= 1'b0;
      redirect_out     <= 1'b0;
      redirect_pc_out  <= '0;
      xy_addr_next_out <= '0;
    end else if (ce_in) begin
      dsp_en_out       <= dsp_en_next;
      rpt_active_out   <= (rc_next != '0) && dsp_en_next;
      redirect_out     <= loop_back;
      redirect_pc_out  <= loop_back ? rs_reg : redirect_pc_out;
      xy_addr_next_out <= xy_next_w;
    end
  end

endmodule : dfd_decode

/* hdl/dfd_pkg.sv */
// constants, field layouts and instruction patterns shared by the dsp
// instruction decoder and its modulo address helper.
// assumes one core clock, and that a 16-bit fetched word arrives with its pc.
// ****************************************************************************
// ****************************************************************************
package dfd_pkg;

  localparam int unsigned HALF_W   = 16;
  localparam int unsigned CODE_W   = 32;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned RC_W     = 12;
  localparam int unsigned XY_W     = 16;
  localparam int unsigned FA_W     = 10;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned GRP_W    = 4;

  // group one-hot positions
  localparam int unsigned GRP_SYS  = 0;
  localparam int unsigned GRP_DDT  = 1;
  localparam int unsigned GRP_SDT  = 2;
  localparam int unsigned GRP_DOP  = 3;

  // leading six bits of a dsp word
  localparam int unsigned PFX_MSB  = 15;
  localparam int unsigned PFX_LSB  = 10;
  localparam logic [5:0]  PFX_DDT  = 6'h3c;
  localparam logic [5:0]  PFX_SDT  = 6'h3d;
  localparam logic [5:0]  PFX_DOP  = 6'h3e;
  localparam logic [5:0]  PFX_RSV  = 6'h3f;

  // transfer field (field a) and operation field (field b) layout
  localparam int unsigned XOP_MSB  = 3;
  localparam int unsigned XOP_LSB  = 2;
  localparam int unsigned YOP_MSB  = 1;
  localparam int unsigned YOP_LSB  = 0;
  localparam int unsigned ALU_MSB  = 7;
  localparam int unsigned ALU_LSB  = 4;
  localparam int unsigned MUL_BIT  = 14;

  // operand positions inside system control words, and the modulo end field of the ldmod register operand
  localparam int unsigned IMM_MSB  = 7;
  localparam int unsigned IMM_LSB  = 0;
  localparam int unsigned SEL_MSB  = 7;
  localparam int unsigned SEL_LSB  = 4;
  localparam logic [SEL_W-1:0] DSPREG_SEL_MIN = 4'h6;
  localparam int unsigned MOD_END_MSB = 31;
  localparam int unsigned MOD_END_LSB = 16;

  // system control patterns: mask and match
  localparam logic [15:0] M_RS     = 16'hf0ff;
  localparam logic [15:0] M_IMM    = 16'hff00;
  localparam logic [15:0] M_FULL   = 16'hffff;
  localparam logic [15:0] M_REG    = 16'hf00f;
  localparam logic [15:0] P_SETRC_R = 16'h4014;
  localparam logic [15:0] P_SETRC_I = 16'h8200;
  localparam logic [15:0] P_LDRS   = 16'h8c00;
  localparam logic [15:0] P_LDRE   = 16'h8e00;
  localparam logic [15:0] P_LDMOD  = 16'h405e;
  localparam logic [15:0] P_LDRS_R = 16'h406e;
  localparam logic [15:0] P_LDRE_R = 16'h407e;
  localparam logic [15:0] P_SETDMX = 16'h0098;
  localparam logic [15:0] P_SETDMY = 16'h00c8;
  localparam logic [15:0] P_CLRDM  = 16'h0088;
  localparam logic [15:0] P_LDSDSP = 16'h400a;
  localparam logic [15:0] P_STSDSP = 16'h000a;

  localparam logic [RC_W-1:0] RC_ONE = 12'h001;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HALF = 2'b10
  } dfd_state_type;

  function automatic logic dfd_hit(input logic [15:0] word,
                                   input logic [15:0] mask,
                                   input logic [15:0] pat);
    dfd_hit = ((word & mask) == pat);
  endfunction : dfd_hit

endpackage : dfd_pkg

/* hdl/dfd_modulo.sv */
// next x/y pointer with optional wrap from buffer end back to buffer start.
// assumes the caller registers the result; this module is purely combinational.
`timescale 1ns/10ps
module dfd_modulo
  import dfd_pkg::*;
(
  input  wire logic [dfd_pkg::XY_W-1:0] addr_in,
  input  wire logic [dfd_pkg::XY_W-1:0] step_in,
  input  wire logic [dfd_pkg::XY_W-1:0] start_in,
  input  wire logic [dfd_pkg::XY_W-1:0] end_in,
  input  wire logic                     wrap_en_in,
  output logic      [dfd_pkg::XY_W-1:0] next_out
);
  wire logic [XY_W-1:0] sum_w = XY_W'(addr_in + step_in);
  wire logic            at_end_w = wrap_en_in && (addr_in == end_in);

  // wrap compares the current pointer, so step must land exactly on the end
  assign next_out = at_end_w ? start_in : sum_w;
endmodule : dfd_modulo

/* sim/dfd_decode_sva.sv */
// properties on the dsp decoder ports, bound to every dfd_decode
// assumes one core clock and an asynchronous active-high reset
`timescale 1ns/10ps
module dfd_chk
  import dfd_pkg::*;
(
  input wire logic        clk_in, rst_in, ce_in, fw_valid_in, priv_in,
  input wire logic        dsp_wr_in, dsp_wdata_in, iss_valid_out, iss_long_out,
  input wire logic        x_xfer_out, y_xfer_out, alu_op_out, mul_op_out,
  input wire logic        dspreg_acc_out, dspreg_load_out, illegal_out,
  input wire logic        dsp_en_out, redirect_out,
  input wire logic [15:0] fw_word_in, op_field_out,
  input wire logic [31:0] fw_pc_in, iss_code_out, iss_pc_out,
  input wire logic [9:0]  xfer_field_out,
  input wire logic [3:0]  iss_grp_out, dspreg_sel_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****************************************************************
  // helper: is the next taken word the lower half of a data op
  // ****************************************************************
  wire logic       take = ce_in && fw_valid_in;
  wire logic [5:0] pfx  = fw_word_in[15:10];
  logic        pend_reg;
  logic [15:0] up_reg;
  logic [31:0] pc_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg <= 1'b0;
      up_reg   <= 16'h0000;
      pc_reg   <= 32'h0000_0000;
    end else if (take) begin
      pend_reg <= !pend_reg && dsp_en_out && pfx == PFX_DOP;
      up_reg   <= fw_word_in;
      pc_reg   <= fw_pc_in;
    end
  end
  sequence s_lead(logic [5:0] p);
    take && !pend_reg && dsp_en_out && !dsp_wr_in && pfx == p;
  endsequence
  sequence s_tail;
    take && pend_reg;
  endsequence
  a_first_quiet: assert property (s_lead(PFX_DOP) |=> !iss_valid_out && !illegal_out)
    else $error("data op upper half produced output");
  a_long_issue: assert property (s_tail |=> iss_valid_out && iss_long_out
    && iss_grp_out == 4'h8) else $error("data op not issued as long group");
  a_long_code: assert property (s_tail |=> iss_code_out == {$past(up_reg),
    $past(fw_word_in)} && iss_pc_out == $past(pc_reg)) else $error("long code or pc wrong");
  a_field_split: assert property (iss_valid_out && iss_long_out |->
    op_field_out == iss_code_out[15:0] && xfer_field_out == iss_code_out[25:16])
    else $error("field split wrong");
  a_par_ops: assert property (iss_valid_out && iss_grp_out == 4'h8 |->
    alu_op_out == (|op_field_out[7:4]) && mul_op_out == op_field_out[14]
    && x_xfer_out == (|xfer_field_out[3:2]) && y_xfer_out == (|xfer_field_out[1:0]))
    else $error("parallel operation flags wrong");
  a_double_issue: assert property (s_lead(PFX_DDT) |=> iss_valid_out && !iss_long_out
    && iss_grp_out == 4'h2 && iss_code_out == {16'h0000, $past(fw_word_in)})
    else $error("double transfer issue wrong");
  a_single_issue: assert property (s_lead(PFX_SDT) |=> iss_valid_out && !iss_long_out
    && iss_grp_out == 4'h4) else $error("single transfer issue wrong");
  a_off_illegal: assert property (take && !pend_reg && !dsp_en_out && !dsp_wr_in
    && fw_word_in[15:12] == 4'hf |=> illegal_out && !iss_valid_out
    && iss_pc_out == $past(fw_pc_in)) else $error("disabled dsp word not flagged");
  a_reserved_bad: assert property (s_lead(PFX_RSV) |=> illegal_out && !iss_valid_out)
    else $error("reserved prefix not flagged");
  a_one_group: assert property (iss_valid_out |-> $onehot0(iss_grp_out) && !illegal_out)
    else $error("issue in more than one group");
  a_en_write: assert property (ce_in && dsp_wr_in && priv_in |=>
    dsp_en_out == $past(dsp_wdata_in)) else $error("dsp enable write lost");
  a_en_guard: assert property (ce_in && !(dsp_wr_in && priv_in) |=> $stable(dsp_en_out))
    else $error("dsp enable changed without privileged write");
  a_dspreg_load: assert property (take && !pend_reg && dsp_en_out && !dsp_wr_in
    && (fw_word_in & M_REG) == P_LDSDSP && fw_word_in[7:4] >= DSPREG_SEL_MIN
    |=> dspreg_acc_out && dspreg_load_out && dspreg_sel_out == $past(fw_word_in[7:4]))
    else $error("dsp register load not signalled");
  a_loop_issue: assert property (redirect_out |-> iss_valid_out)
    else $error("loop back without an issue");
endmodule : dfd_chk

bind dfd_decode dfd_chk chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .fw_valid_in(fw_valid_in), .priv_in(priv_in), .dsp_wr_in(dsp_wr_in),
  .dsp_wdata_in(dsp_wdata_in), .iss_valid_out(iss_valid_out), .iss_long_out(iss_long_out),
  .x_xfer_out(x_xfer_out), .y_xfer_out(y_xfer_out), .alu_op_out(alu_op_out),
  .mul_op_out(mul_op_out), .dspreg_acc_out(dspreg_acc_out), .illegal_out(illegal_out),
  .dspreg_load_out(dspreg_load_out), .dsp_en_out(dsp_en_out), .redirect_out(redirect_out),
  .fw_word_in(fw_word_in), .op_field_out(op_field_out), .fw_pc_in(fw_pc_in),
  .iss_code_out(iss_code_out), .iss_pc_out(iss_pc_out), .xfer_field_out(xfer_field_out),
  .iss_grp_out(iss_grp_out), .dspreg_sel_out(dspreg_sel_out));

/* sim/dfd_fetch_model.sv */
// fetch path model: hands 16-bit words to the decoder with their pc
// assumes the bench calls its tasks; a loop-back redirect restarts the pc
`timescale 1ns/10ps
module dfd_fetch_model (
  input  wire logic        clk_in,
  input  wire logic        redirect_in,
  input  wire logic [31:0] redirect_pc_in,
  output logic             fw_valid_out,
  output logic      [15:0] fw_word_out,
  output logic      [31:0] fw_pc_out
);
  logic [31:0] next_pc = 32'h0000_0000;
  initial begin
    fw_valid_out = 1'b0;
    fw_word_out  = 16'h0000;
    fw_pc_out    = 32'h0000_0000;
  end
  task automatic word_out(input logic [15:0] w);
    @(posedge clk_in);
    #1;
    fw_valid_out = 1'b1;
    fw_word_out  = w;
    fw_pc_out    = next_pc;
    next_pc      = next_pc + 32'd2;
  endtask : word_out
  // released lines show the inverse, so a stale word never passes as fresh
  task automatic idle();
    @(posedge clk_in);
    #1;
    fw_valid_out = 1'b0;
    fw_word_out  = ~fw_word_out;
    fw_pc_out    = ~fw_pc_out;
    if (redirect_in === 1'b1) next_pc = redirect_pc_in;
  endtask : idle
  task automatic put16(input logic [15:0] w);
    word_out(w);
    idle();
  endtask : put16
  // gap idle cycles between the halves model a slow fetch
  task automatic put32(input logic [31:0] c, input int gap);
    word_out(c[31:16]);
    repeat (gap) idle();
    word_out(c[15:0]);
    idle();
  endtask : put32
endmodule : dfd_fetch_model

/* sim/dfd_decode_test.sv */
// self-checking bench for the dsp instruction decoder
// assumes dfd_pkg, dfd_decode, dfd_fetch_model and the bound checker
`timescale 1ns/10ps
module dfd_decode_test;
  import dfd_pkg::*;
  logic        clk_in, rst_in, ce_in, priv_in, dsp_wr_in, dsp_wdata_in, xy_is_y_in;
  logic        fw_valid_in, iss_valid_out, iss_long_out, x_xfer_out, y_xfer_out;
  logic        alu_op_out, mul_op_out, dspreg_acc_out, dspreg_load_out, illegal_out;
  logic        dsp_en_out, rpt_active_out, redirect_out;
  logic [15:0] fw_word_in, op_field_out, xy_addr_next_out, xy_addr_in, xy_step_in;
  logic [31:0] fw_pc_in, iss_code_out, iss_pc_out, redirect_pc_out, opnd_in;
  logic [9:0]  xfer_field_out;
  logic [3:0]  iss_grp_out, dspreg_sel_out;
  int          n_mismatch = 0;
  int          n_tests = 0;
  dfd_decode uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .fw_valid_in(fw_valid_in),
    .fw_word_in(fw_word_in), .fw_pc_in(fw_pc_in), .priv_in(priv_in), .dsp_wr_in(dsp_wr_in),
    .dsp_wdata_in(dsp_wdata_in), .opnd_in(opnd_in), .xy_addr_in(xy_addr_in),
    .xy_step_in(xy_step_in), .xy_is_y_in(xy_is_y_in), .iss_valid_out(iss_valid_out),
    .iss_grp_out(iss_grp_out), .iss_code_out(iss_code_out), .iss_pc_out(iss_pc_out),
    .iss_long_out(iss_long_out), .xfer_field_out(xfer_field_out),
    .op_field_out(op_field_out), .x_xfer_out(x_xfer_out), .y_xfer_out(y_xfer_out),
    .alu_op_out(alu_op_out), .mul_op_out(mul_op_out), .dspreg_acc_out(dspreg_acc_out),
    .dspreg_load_out(dspreg_load_out), .dspreg_sel_out(dspreg_sel_out),
    .illegal_out(illegal_out), .dsp_en_out(dsp_en_out), .rpt_active_out(rpt_active_out),
    .redirect_out(redirect_out), .redirect_pc_out(redirect_pc_out),
    .xy_addr_next_out(xy_addr_next_out));
  dfd_fetch_model fm (.clk_in(clk_in), .redirect_in(redirect_out),
    .redirect_pc_in(redirect_pc_out), .fw_valid_out(fw_valid_in),
    .fw_word_out(fw_word_in), .fw_pc_out(fw_pc_in));
  // ****************************************************************
  // clock, checks and closing
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // the whole run needs well under 1000 cycles
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
  task automatic dsp_set(input logic priv, input logic v);
    @(posedge clk_in);
    #1;
    priv_in = priv;
    dsp_wr_in = 1'b1;
    dsp_wdata_in = v;
    @(posedge clk_in);
    #1;
    dsp_wr_in = 1'b0;
    chk("dsp enable", priv ? v : 1'b0, dsp_en_out);
  endtask : dsp_set
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_off();
    logic [15:0] w[4] = '{16'hf000, 16'hf800, 16'h0088, 16'h8203};
    fm.next_pc = 32'h0000_0200;
    for (int i = 0; i < 4; i++) begin
      fm.put16(w[i]);
      chk("illegal", 1'b1, illegal_out);
      chk("issue", 1'b0, iss_valid_out);
      chk("illegal pc", 32'h0000_0200 + 2 * i, iss_pc_out);
    end
  endtask : t_off
  task automatic t_groups();
    logic [15:0] w[5] = '{16'hf004, 16'hf401, 16'h6003, 16'h0088, 16'hfc00};
    logic [3:0]  g[5] = '{4'h2, 4'h4, 4'h0, 4'h1, 4'h0};
    for (int i = 0; i < 5; i++) begin
      fm.put16(w[i]);
      chk("issue", i != 4, iss_valid_out);
      chk("illegal", i == 4, illegal_out);
      if (i < 4) chk("group", g[i], iss_grp_out);
    end
  endtask : t_groups
  task automatic chk_long(input logic [31:0] c, input logic [31:0] pc);
    chk("long issue", 3'b111, {iss_valid_out, iss_long_out, iss_grp_out == 4'h8});
    chk("long code", c, iss_code_out);
    chk("long pc", pc, iss_pc_out);
    chk("field a", c[25:16], xfer_field_out);
    chk("field b", c[15:0], op_field_out);
    chk("ops", {|c[7:4], c[14], |c[19:18], |c[17:16]},
      {alu_op_out, mul_op_out, x_xfer_out, y_xfer_out});
  endtask : chk_long
  task automatic t_long();
    fm.next_pc = 32'h0000_0302;
    fm.put32(32'hf800_1234, 3);
    chk_long(32'hf800_1234, 32'h0000_0302);
    ce_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    ce_in = 1'b1;
    chk_long(32'hf800_1234, 32'h0000_0302);
    fm.put32(32'hf805_4070, 0);
    chk_long(32'hf805_4070, 32'h0000_0306);
  endtask : t_long
  task automatic t_dspreg();
    fm.put16(16'h406a);
    chk("load access", {1'b1, 1'b1, 4'h6}, {dspreg_acc_out, dspreg_load_out, dspreg_sel_out});
    fm.put16(16'h007a);
    chk("store access", {1'b1, 1'b0, 4'h7}, {dspreg_acc_out, dspreg_load_out, dspreg_sel_out});
  endtask : t_dspreg
  task automatic t_modulo();
    logic [15:0] a[5] = '{16'h0040, 16'h0020, 16'h0040, 16'h0040, 16'h0040};
    logic [15:0] e[5] = '{16'h0010, 16'h0023, 16'h0044, 16'h0010, 16'h0046};
    opnd_in = {16'h0040, 16'h0010};
    fm.put16(16'h415e);
    fm.put16(16'h0098);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) fm.put16(16'h00c8);
      if (i == 4) fm.put16(16'h0088);
      xy_addr_in = a[i];
      xy_step_in = 16'h0002 + 16'(i);
      xy_is_y_in = (i >= 2);
      @(posedge clk_in);
      #1;
      chk("next pointer", e[i], xy_addr_next_out);
    end
  endtask : t_modulo
  task automatic t_repeat();
    fm.next_pc = 32'h0000_0100;
    fm.put16(16'h8203);
    fm.put16(16'h8c02);
    fm.put16(16'h8e02);
    chk("repeat active", 1'b1, rpt_active_out);
    for (int r = 0; r < 3; r++) begin
      repeat (2) fm.put16(16'h0009);
      chk("loop end pc", 32'h0000_0108, iss_pc_out);
      chk("loop back", r < 2, redirect_out);
      if (r < 2) chk("loop target", 32'h0000_0106, redirect_pc_out);
    end
    chk("repeat done", 1'b0, rpt_active_out);
  endtask : t_repeat
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    priv_in = 1'b0;
    dsp_wr_in = 1'b0;
    dsp_wdata_in = 1'b0;
    opnd_in = 32'h0000_0000;
    xy_addr_in = 16'h0000;
    xy_step_in = 16'h0002;
    xy_is_y_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk("dsp enable after reset", 1'b0, dsp_en_out);
    t_off();
    dsp_set(1'b0, 1'b1);
    dsp_set(1'b1, 1'b1);
    t_groups();
    t_long();
    t_dspreg();
    t_modulo();
    t_repeat();
    dsp_set(1'b1, 1'b0);
    t_off();
    final_report();
  end
endmodule : dfd_decode_test
